// >>> core/bram_pkg.sv
package bram_pkg;

    // Memory arrangements the block can be built as
    typedef enum logic [1:0] {
        MODE_SINGLE      = 2'h0,
        MODE_SIMPLE_DUAL = 2'h1,
        MODE_TRUE_DUAL   = 2'h2
    } ram_mode_e;

    // Default geometry
    localparam int DEF_DATA_W = 32;
    localparam int DEF_DEPTH = 1024;
    localparam int DEF_BYTE_SIZE = 8;

    // Reset value of every output stage and flag
    localparam logic OUT_RESET = 1'b0;

    // Upper bound on check bits searched for the code
    localparam int MAX_PARITY_W = 12;

    // Number of Hamming check bits for a data width, overall parity excluded
    function automatic int ecc_parity_w(input int dw);
        int p;
        p = 0;
        for (int k = 1; k < MAX_PARITY_W; k++) begin
            if (p == 0 && (1 << k) >= dw + k + 1) begin
                p = k;
            end
        end
        return p;
    endfunction

    // Codeword position of data bit idx; powers of two hold check bits
    function automatic int data_position(input int idx);
        int r;
        r = idx + 3;
        for (int k = 2; k < MAX_PARITY_W; k++) begin
            if ((1 << k) <= r) begin
                r = r + 1;
            end
        end
        return r;
    endfunction

endpackage

// >>> core/ecc_word_if.sv
`timescale 1ns/1ns
// Carries one word between the array and the code logic
interface ecc_word_if #(
    parameter int DATA_W = 32,
    parameter int PAR_W = 6
);
    logic [DATA_W-1:0] plain_word;
    logic [DATA_W+PAR_W:0] stored_word;
    logic force_single;
    logic force_double;
    logic single_flag;
    logic double_flag;

    modport encoder (
        input plain_word,
        input force_single,
        input force_double,
        output stored_word
    );

    modport decoder (
        input stored_word,
        output plain_word,
        output single_flag,
        output double_flag
    );
endinterface

// >>> core/ecc_word_encoder.sv
`timescale 1ns/1ns
module ecc_word_encoder #(
    parameter int DATA_W = 32,
    parameter int PAR_W = 6
)(
    ecc_word_if.encoder link
);

    // Check bits, overall parity, then optional forced corruption of data bits
    always_comb begin
        logic [DATA_W-1:0] d;
        logic [PAR_W-1:0] chk;
        logic [DATA_W+PAR_W:0] word;
        int pos;
        d = link.plain_word;
        chk = '0;
        pos = 0;
        word = '0;
        for (int i = 0; i < DATA_W; i++) begin
            pos = bram_pkg::data_position(i);
            for (int j = 0; j < PAR_W; j++) begin
                if (pos[j]) begin
                    chk[j] = chk[j] ^ d[i];
                end
            end
        end
        word = {(^d) ^ (^chk), chk, d};
        if (link.force_double) begin
            word[1:0] = ~word[1:0]; // RQ19
        end else if (link.force_single) begin
            word[0] = ~word[0]; // RQ19
        end
        link.stored_word = word;
    end

endmodule // ecc_word_encoder

// >>> core/ecc_word_decoder.sv
`timescale 1ns/1ns
module ecc_word_decoder #(
    parameter int DATA_W = 32,
    parameter int PAR_W = 6
)(
    ecc_word_if.decoder link
);

    // Syndrome, overall parity check and single-bit repair
    always_comb begin
        logic [DATA_W-1:0] d;
        logic [PAR_W-1:0] syn;
        logic parity_bad;
        int pos;
        d = link.stored_word[DATA_W-1:0];
        syn = link.stored_word[DATA_W+PAR_W-1:DATA_W];
        pos = 0;
        parity_bad = 1'b0;
        for (int i = 0; i < DATA_W; i++) begin
            pos = bram_pkg::data_position(i);
            for (int j = 0; j < PAR_W; j++) begin
                if (pos[j]) begin
                    syn[j] = syn[j] ^ d[i];
                end
            end
        end
        parity_bad = ^link.stored_word;
        for (int i = 0; i < DATA_W; i++) begin
            if (parity_bad && syn == PAR_W'(bram_pkg::data_position(i))) begin
                d[i] = ~d[i]; // RQ14
            end
        end
        link.plain_word = d;
        link.single_flag = parity_bad; // RQ14
        link.double_flag = !parity_bad && syn != '0; // RQ15
    end

endmodule // ecc_word_decoder

// >>> core/dual_port_block_ram_ecc.sv
`timescale 1ns/1ns
// Behaviour
// RQ1 - Both ports run on one shared clock
// RQ2 - Address width fits configured memory depth
// RQ3 - Write gate one bit, or per byte
// RQ4 - Port A clock gate enables every operation
// RQ5 - Port A writes only when gated
// RQ6 - Port A clear resets output, not memory
// RQ7 - Port A final stage loads when enabled
// RQ8 - Port A read output absent in simple dual
// RQ9 - Port B address and read in dual modes
// RQ10 - Port B writes only in true dual
// RQ11 - Port B clock gate and write strobe
// RQ12 - Port B clear resets its output
// RQ13 - Port B final stage load enable
// RQ14 - Correct single-bit errors and flag them
// RQ15 - Flag uncorrectable double-bit errors
// RQ16 - Error inject inputs and failing address output
// RQ17 - Interface sampled on rising clock edge
// RQ18 - Active-low bus reset clears interface logic
// RQ19 - Forced errors corrupt stored word bits
// RQ20 - Flags and address follow read data stages
module dual_port_block_ram_ecc #(
    parameter bram_pkg::ram_mode_e MEM_MODE = bram_pkg::MODE_TRUE_DUAL,
    parameter int DATA_W = bram_pkg::DEF_DATA_W,
    parameter int DEPTH = bram_pkg::DEF_DEPTH,
    parameter bit BYTE_WRITES = 1'b0,
    parameter int BYTE_SIZE = bram_pkg::DEF_BYTE_SIZE,
    parameter bit ECC_ON = 1'b0,
    parameter bit A_OUT_REG = 1'b0,
    parameter bit B_OUT_REG = 1'b0,
    localparam int ADDR_W = $clog2(DEPTH), // RQ2
    localparam int LANES = (BYTE_WRITES && !ECC_ON) ? DATA_W / BYTE_SIZE : 1
)(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic bus_side_reset_low,
    input wire logic port_a_clock_gate,
    input wire logic [LANES-1:0] port_a_write_gate,
    input wire logic [ADDR_W-1:0] port_a_location,
    input wire logic [DATA_W-1:0] port_a_write_word,
    input wire logic port_a_output_clear,
    input wire logic port_a_final_stage_gate,
    output logic [DATA_W-1:0] port_a_read_word,
    input wire logic port_b_clock_gate,
    input wire logic [LANES-1:0] port_b_write_strobe,
    input wire logic [ADDR_W-1:0] port_b_location,
    input wire logic [DATA_W-1:0] port_b_write_word,
    input wire logic port_b_output_clear,
    input wire logic port_b_final_stage_gate,
    output logic [DATA_W-1:0] port_b_read_word,
    input wire logic force_single_flip,
    input wire logic force_double_flip,
    output logic single_flip_corrected_flag,
    output logic double_flip_detected_flag,
    output logic [ADDR_W-1:0] faulty_word_location
);

    // Derived geometry and which features this arrangement carries
    localparam int PAR_W = bram_pkg::ecc_parity_w(DATA_W);
    localparam int STORE_W = ECC_ON ? DATA_W + PAR_W + 1 : DATA_W;
    localparam int LANE_W = STORE_W / LANES;
    localparam bit A_READS = MEM_MODE != bram_pkg::MODE_SIMPLE_DUAL;
    localparam bit B_PRESENT = MEM_MODE != bram_pkg::MODE_SINGLE;
    localparam bit B_WRITES = MEM_MODE == bram_pkg::MODE_TRUE_DUAL;
    localparam bit ECC_REG = B_PRESENT ? B_OUT_REG : A_OUT_REG;

    // Read pipeline of both ports plus the error report beside it
    typedef struct packed {
        logic [DATA_W-1:0] a_latch;
        logic [DATA_W-1:0] a_reg;
        logic [DATA_W-1:0] b_latch;
        logic [DATA_W-1:0] b_reg;
        logic [1:0] flags_latch;
        logic [1:0] flags_reg;
        logic [ADDR_W-1:0] loc_latch;
        logic [ADDR_W-1:0] loc_reg;
    } pipe_s;

    pipe_s pipe_reg;
    pipe_s pipe_next;
    logic [STORE_W-1:0] mem [DEPTH];
    logic clear_all;
    logic a_op;
    logic b_op;
    logic ecc_op;
    logic ecc_clear;
    logic ecc_final;
    logic [LANES-1:0] a_wr;
    logic [LANES-1:0] b_wr;
    logic [STORE_W-1:0] a_store;
    logic [STORE_W-1:0] b_store;
    logic [STORE_W-1:0] a_raw;
    logic [STORE_W-1:0] b_raw;
    logic [ADDR_W-1:0] ecc_addr;
    logic [DATA_W-1:0] ecc_data;
    logic [1:0] ecc_flags;
    logic [DATA_W-1:0] a_read;
    logic [DATA_W-1:0] b_read;

    // Either reset input clears the interface logic; memory keeps its contents
    assign clear_all = sys_rst || !bus_side_reset_low; // RQ18

    // Operation enables; every port action needs its clock gate
    assign a_op = port_a_clock_gate; // RQ4
    assign b_op = B_PRESENT && port_b_clock_gate; // RQ11
    assign a_wr = a_op ? port_a_write_gate : '0; // RQ5
    assign b_wr = (B_WRITES && b_op) ? port_b_write_strobe : '0; // RQ10

    // The error checked port is B when present, otherwise A
    assign ecc_addr = B_PRESENT ? port_b_location : port_a_location;
    assign ecc_op = B_PRESENT ? b_op : a_op;
    assign ecc_clear = B_PRESENT ? port_b_output_clear : port_a_output_clear;
    assign ecc_final = B_PRESENT ? port_b_final_stage_gate : port_a_final_stage_gate;

    // Raw array reads at both addresses
    assign a_raw = mem[port_a_location];
    assign b_raw = mem[port_b_location]; // RQ9

    // Port B write word widened to the stored width; written with zero check bits under ECC
    assign b_store = STORE_W'(port_b_write_word);

    // Optional code logic: encode port A writes, decode the checked read
    generate
        if (ECC_ON) begin : g_ecc
            ecc_word_if #(.DATA_W(DATA_W), .PAR_W(PAR_W)) enc_bus ();
            ecc_word_if #(.DATA_W(DATA_W), .PAR_W(PAR_W)) dec_bus ();

            // Write side with forced corruption
            assign enc_bus.plain_word = port_a_write_word;
            assign enc_bus.force_single = force_single_flip; // RQ16
            assign enc_bus.force_double = force_double_flip; // RQ16
            ecc_word_encoder #(.DATA_W(DATA_W), .PAR_W(PAR_W)) u_encoder (
                .link(enc_bus)
            );
            assign a_store = enc_bus.stored_word;

            // Read side of the checked port
            assign dec_bus.stored_word = mem[ecc_addr];
            ecc_word_decoder #(.DATA_W(DATA_W), .PAR_W(PAR_W)) u_decoder (
                .link(dec_bus)
            );
            assign ecc_data = dec_bus.plain_word; // RQ14
            assign ecc_flags = {dec_bus.double_flag, dec_bus.single_flag}; // RQ15
        end else begin : g_plain
            assign a_store = port_a_write_word;
            assign ecc_data = '0;
            assign ecc_flags = 2'h0;
        end
    endgenerate

    // Word each port presents to its latch
    assign a_read = (ECC_ON && !B_PRESENT) ? ecc_data : a_raw[DATA_W-1:0];
    assign b_read = ECC_ON ? ecc_data : b_raw[DATA_W-1:0];

    // Array writes lane by lane; port A wins a same-address collision
    always_ff @(posedge clock) begin // RQ1
        for (int l = 0; l < LANES; l++) begin
            if (b_wr[l]) begin
                mem[port_b_location][l*LANE_W +: LANE_W] <= b_store[l*LANE_W +: LANE_W]; // RQ11
            end
            if (a_wr[l]) begin
                mem[port_a_location][l*LANE_W +: LANE_W] <= a_store[l*LANE_W +: LANE_W]; // RQ3
            end
        end
    end

    // Next state of latches, final stages and error report
    always_comb begin
        pipe_next = pipe_reg;

        // Port A latch, then optional final stage
        if (a_op) begin
            if (port_a_output_clear && !A_OUT_REG) begin
                pipe_next.a_latch = '0; // RQ6
            end else begin
                pipe_next.a_latch = a_read;
            end
            if (A_OUT_REG) begin
                if (port_a_output_clear) begin
                    pipe_next.a_reg = '0; // RQ6
                end else if (port_a_final_stage_gate) begin
                    pipe_next.a_reg = pipe_reg.a_latch; // RQ7
                end
            end
        end

        // Port B latch, then optional final stage
        if (b_op) begin
            if (port_b_output_clear && !B_OUT_REG) begin
                pipe_next.b_latch = '0; // RQ12
            end else begin
                pipe_next.b_latch = b_read;
            end
            if (B_OUT_REG) begin
                if (port_b_output_clear) begin
                    pipe_next.b_reg = '0; // RQ12
                end else if (port_b_final_stage_gate) begin
                    pipe_next.b_reg = pipe_reg.b_latch; // RQ13
                end
            end
        end

        // Error report travels with the checked port's data
        if (ECC_ON && ecc_op) begin
            if (ecc_clear && !ECC_REG) begin
                pipe_next.flags_latch = 2'h0;
                pipe_next.loc_latch = '0;
            end else begin
                pipe_next.flags_latch = ecc_flags; // RQ20
                pipe_next.loc_latch = ecc_addr; // RQ16
            end
            if (ECC_REG) begin
                if (ecc_clear) begin
                    pipe_next.flags_reg = 2'h0;
                    pipe_next.loc_reg = '0;
                end else if (ecc_final) begin
                    pipe_next.flags_reg = pipe_reg.flags_latch; // RQ20
                    pipe_next.loc_reg = pipe_reg.loc_latch; // RQ20
                end
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clock) begin // RQ17
        if (clear_all) begin
            pipe_reg <= {$bits(pipe_s){bram_pkg::OUT_RESET}}; // RQ18
        end else begin
            pipe_reg <= pipe_next;
        end
    end

    // Outputs; absent ports read zero in arrangements that lack them
    assign port_a_read_word = !A_READS ? '0 : (A_OUT_REG ? pipe_reg.a_reg : pipe_reg.a_latch); // RQ8
    assign port_b_read_word = !B_PRESENT ? '0 : (B_OUT_REG ? pipe_reg.b_reg : pipe_reg.b_latch); // RQ9
    assign single_flip_corrected_flag = ECC_REG ? pipe_reg.flags_reg[0] : pipe_reg.flags_latch[0];
    assign double_flip_detected_flag = ECC_REG ? pipe_reg.flags_reg[1] : pipe_reg.flags_latch[1];
    assign faulty_word_location = ECC_REG ? pipe_reg.loc_reg : pipe_reg.loc_latch; // RQ16

endmodule // dual_port_block_ram_ecc

// >>> tb/dual_port_block_ram_ecc_assertions.sv
`timescale 1ns/1ns
module ram_port_checker #(
    parameter bram_pkg::ram_mode_e MEM_MODE = bram_pkg::MODE_TRUE_DUAL,
    parameter int DEPTH = 1024,
    parameter bit B_OUT_REG = 1'b0,
    parameter int DATA_W = 32,
    localparam int ADDR_W = $clog2(DEPTH)
)(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic bus_side_reset_low,
    input wire logic port_b_clock_gate,
    input wire logic port_b_output_clear,
    input wire logic port_b_final_stage_gate,
    input wire logic [ADDR_W-1:0] port_b_location,
    input wire logic [DATA_W-1:0] port_a_read_word,
    input wire logic [DATA_W-1:0] port_b_read_word,
    input wire logic single_flip_corrected_flag,
    input wire logic double_flip_detected_flag,
    input wire logic [ADDR_W-1:0] faulty_word_location
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst || !bus_side_reset_low);

    // Gated port B load of latch and final stage, twice in a row
    sequence b_load;
        port_b_clock_gate && port_b_final_stage_gate && !port_b_output_clear;
    endsequence
    sequence b_two_loads;
        b_load ##1 b_load;
    endsequence

    a_word_absent_a: assert property (MEM_MODE == bram_pkg::MODE_SIMPLE_DUAL |-> port_a_read_word == '0)
        else $error("port A read word not zero in simple dual mode");
    b_idle_hold_a: assert property (!port_b_clock_gate |=> $stable(port_b_read_word))
        else $error("port B output moved with its clock gate low");
    flags_idle_a: assert property (!port_b_clock_gate |=> $stable(single_flip_corrected_flag)
        && $stable(double_flip_detected_flag) && $stable(faulty_word_location))
        else $error("error flags moved with port B idle");
    b_final_hold_a: assert property (B_OUT_REG && port_b_clock_gate && !port_b_final_stage_gate
        && !port_b_output_clear |=> $stable(port_b_read_word) && $stable(single_flip_corrected_flag))
        else $error("port B final stage loaded without its gate");
    b_clear_a: assert property (port_b_clock_gate && port_b_output_clear |=> port_b_read_word == '0
        && !single_flip_corrected_flag && !double_flip_detected_flag)
        else $error("port B output not cleared");
    flags_exclusive_a: assert property (!(single_flip_corrected_flag && double_flip_detected_flag))
        else $error("single and double error flags both set");
    fault_location_a: assert property (b_two_loads |=> !B_OUT_REG
        || !(single_flip_corrected_flag || double_flip_detected_flag)
        || faulty_word_location == $past(port_b_location, 2))
        else $error("faulty location differs from the read address");
    reset_clear_a: assert property (disable iff (1'b0) (sys_rst || !bus_side_reset_low) |=>
        port_b_read_word == '0 && port_a_read_word == '0 && faulty_word_location == '0
        && !single_flip_corrected_flag && !double_flip_detected_flag)
        else $error("outputs not cleared by reset");
endmodule // ram_port_checker

bind dual_port_block_ram_ecc ram_port_checker #(.MEM_MODE(MEM_MODE), .DEPTH(DEPTH),
    .B_OUT_REG(B_OUT_REG), .DATA_W(DATA_W)) ram_port_checker_i (.clock(clock),
    .sys_rst(sys_rst), .bus_side_reset_low(bus_side_reset_low),
    .port_b_clock_gate(port_b_clock_gate), .port_b_output_clear(port_b_output_clear),
    .port_b_final_stage_gate(port_b_final_stage_gate), .port_b_location(port_b_location),
    .port_a_read_word(port_a_read_word), .port_b_read_word(port_b_read_word),
    .single_flip_corrected_flag(single_flip_corrected_flag),
    .double_flip_detected_flag(double_flip_detected_flag),
    .faulty_word_location(faulty_word_location));

// >>> tb/ram_port_user.sv
`timescale 1ns/1ns
module ram_port_user (
    input wire logic clock,
    output logic port_a_clock_gate,
    output logic port_a_write_gate,
    output logic [3:0] port_a_location,
    output logic [7:0] port_a_write_word,
    output logic force_single_flip,
    output logic force_double_flip,
    output logic port_b_clock_gate,
    output logic [3:0] port_b_location,
    output logic port_b_final_stage_gate,
    output logic port_b_output_clear
);
    // Idle levels from time zero
    initial begin
        {port_a_clock_gate, port_a_write_gate, force_single_flip, force_double_flip} = 4'h0;
        {port_b_clock_gate, port_b_final_stage_gate, port_b_output_clear} = 3'h0;
        port_a_location = 4'h0;
        port_a_write_word = 8'h00;
        port_b_location = 4'h0;
    end

    // Port A write: driven after a falling edge, taken at the next rising edge
    task automatic put_a(input logic [3:0] loc, input logic [7:0] word, input logic gate,
                         input logic wr, input logic fs, input logic fd);
        port_a_clock_gate = gate;
        port_a_write_gate = wr;
        port_a_location = loc;
        port_a_write_word = word;
        force_single_flip = fs;
        force_double_flip = fd;
        @(negedge clock);
        port_a_clock_gate = 1'b0;
        port_a_write_gate = 1'b0;
        port_a_location = ~loc; // Released lines show no stale value
        port_a_write_word = ~word;
        force_single_flip = 1'b0;
        force_double_flip = 1'b0;
        @(negedge clock); // Idle edge keeps back-to-back calls apart
    endtask

    // Port B read through latch then final stage, two rising edges
    task automatic get_b(input logic [3:0] loc, input logic fin);
        port_b_clock_gate = 1'b1;
        port_b_final_stage_gate = fin;
        port_b_location = loc;
        repeat (2) @(negedge clock);
        port_b_clock_gate = 1'b0;
        port_b_final_stage_gate = 1'b0;
        port_b_location = ~loc;
        @(negedge clock); // Idle edge keeps back-to-back calls apart
    endtask

    // Port B output clear for one edge at a written location
    task automatic clear_b(input logic [3:0] loc);
        port_b_clock_gate = 1'b1;
        port_b_output_clear = 1'b1;
        port_b_location = loc;
        @(negedge clock);
        port_b_clock_gate = 1'b0;
        port_b_output_clear = 1'b0;
        port_b_location = ~loc;
        @(negedge clock);
    endtask
endmodule // ram_port_user

// >>> tb/tb_dual_port_block_ram_ecc.sv
`timescale 1ns/1ns
module tb_dual_port_block_ram_ecc;
    typedef struct {
        logic [3:0] loc;
        logic [7:0] word;
        logic fs;
        logic fd;
        logic [7:0] exp_word;
        logic exp_s;
        logic exp_d;
    } row_s;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_side_reset_low = 1'b1;
    logic a_gate, a_wr, fs, fd, b_gate, b_fin, b_clr, sflag, dflag;
    logic [3:0] a_loc, b_loc, floc;
    logic [7:0] a_word_in, a_word, b_word;
    logic a_clr = 1'b0;
    logic a_fin = 1'b0;
    logic b_ws = 1'b0;
    logic [7:0] b_wword = 8'h00;
    int n_fail = 0;
    int checks_done = 0;
    // Double error leaves the two forced data bits flipped on the output
    row_s rows[4] = '{'{4'h3, 8'hA5, 1'b0, 1'b0, 8'hA5, 1'b0, 1'b0},
                      '{4'h7, 8'h3C, 1'b1, 1'b0, 8'h3C, 1'b1, 1'b0},
                      '{4'hB, 8'h81, 1'b0, 1'b1, 8'h82, 1'b0, 1'b1},
                      '{4'h0, 8'hFF, 1'b0, 1'b0, 8'hFF, 1'b0, 1'b0}};

    // 20 MHz clock
    always #25 clock = ~clock;

    dual_port_block_ram_ecc #(.MEM_MODE(bram_pkg::MODE_SIMPLE_DUAL), .DATA_W(8), .DEPTH(16),
        .ECC_ON(1'b1), .B_OUT_REG(1'b1)) dual_port_block_ram_ecc_i (.clock(clock),
        .sys_rst(sys_rst), .bus_side_reset_low(bus_side_reset_low),
        .port_a_clock_gate(a_gate), .port_a_write_gate(a_wr), .port_a_location(a_loc),
        .port_a_write_word(a_word_in), .port_a_output_clear(a_clr),
        .port_a_final_stage_gate(a_fin), .port_a_read_word(a_word),
        .port_b_clock_gate(b_gate), .port_b_write_strobe(b_ws), .port_b_location(b_loc),
        .port_b_write_word(b_wword), .port_b_output_clear(b_clr),
        .port_b_final_stage_gate(b_fin), .port_b_read_word(b_word),
        .force_single_flip(fs), .force_double_flip(fd),
        .single_flip_corrected_flag(sflag), .double_flip_detected_flag(dflag),
        .faulty_word_location(floc));

    ram_port_user ram_port_user_i (.clock(clock), .port_a_clock_gate(a_gate),
        .port_a_write_gate(a_wr), .port_a_location(a_loc), .port_a_write_word(a_word_in),
        .force_single_flip(fs), .force_double_flip(fd), .port_b_clock_gate(b_gate),
        .port_b_location(b_loc), .port_b_final_stage_gate(b_fin), .port_b_output_clear(b_clr));

    // Compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected 43 cycles
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end

    // Table of writes and reads, then the awkward cases
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        chk("b_word_reset", 8'h00, b_word);
        for (int i = 0; i < 4; i++) begin
            ram_port_user_i.put_a(rows[i].loc, rows[i].word, 1'b1, 1'b1, rows[i].fs, rows[i].fd);
            ram_port_user_i.get_b(rows[i].loc, 1'b1);
            chk("b_word", rows[i].exp_word, b_word);
            chk("single_flag", {7'h00, rows[i].exp_s}, {7'h00, sflag});
            chk("double_flag", {7'h00, rows[i].exp_d}, {7'h00, dflag});
            if (rows[i].exp_s || rows[i].exp_d) chk("location", {4'h0, rows[i].loc}, {4'h0, floc});
            chk("a_word", 8'h00, a_word);
            $display("row %0d done", i);
        end
        ram_port_user_i.put_a(4'h3, 8'h11, 1'b1, 1'b0, 1'b0, 1'b0);
        ram_port_user_i.put_a(4'h3, 8'h22, 1'b0, 1'b1, 1'b0, 1'b0);
        ram_port_user_i.get_b(4'h3, 1'b1);
        chk("refused_writes", 8'hA5, b_word);
        $display("refused writes done");
        ram_port_user_i.get_b(4'h7, 1'b0);
        chk("final_hold_word", 8'hA5, b_word);
        chk("final_hold_flag", 8'h00, {7'h00, sflag});
        $display("final stage hold done");
        a_clr = 1'b1;
        a_fin = 1'b1;
        b_ws = 1'b1;
        b_wword = 8'h5A;
        ram_port_user_i.clear_b(4'h7);
        chk("cleared_word", 8'h00, b_word);
        ram_port_user_i.get_b(4'h3, 1'b1);
        chk("memory_kept", 8'hA5, b_word);
        chk("a_word_absent", 8'h00, a_word);
        $display("output clear done");
        b_ws = 1'b0;
        b_wword = 8'h00;
        a_clr = 1'b0;
        a_fin = 1'b0;
        ram_port_user_i.get_b(4'h3, 1'b1);
        chk("b_write_refused", 8'hA5, b_word);
        $display("port B write refused done");
        bus_side_reset_low = 1'b0;
        @(negedge clock);
        bus_side_reset_low = 1'b1;
        chk("bus_reset_word", 8'h00, b_word);
        chk("bus_reset_loc", 8'h00, {4'h0, floc});
        $display("bus reset done");
        give_verdict();
    end
endmodule // tb_dual_port_block_ram_ecc
